// ===== design/serial_rx_phase_align_deserializer.sv
// Purpose: One receive channel: phase aligner, phase FIFO, bit slip,
//          deserializer with SDR/DDR bypass, APB control
// Assumes: Eight phase samples of the line arrive per pclk bit time
// Notes: Summary of operation follows
//
// Summary of operation
// R1 - Sample with nearest of eight phases
// R2 - Keep tracking and re-pick best phase
// R3 - Hold stops phase changes
// R4 - Lock from any data transitions
// R5 - Lock flag sticky until reset
// R6 - Aligner reset forces retraining
// R7 - Six-entry one-bit FIFO absorbs phase
// R8 - FIFO resets on first lock or command
// R9 - FIFO and aligner bypassed per mode
// R10 - Each slip edge adds one bit
// R11 - Slip high and low one parallel cycle
// R12 - Realigned data two parallel cycles later
// R13 - Rollover point programmable 1 to 11
// R14 - Rollover flag pulses one parallel cycle
// R15 - Deserialize factor 3 to 10
// R16 - Bypass gives SDR 1 or DDR 2 bits
// R17 - Bypass disables aligner and slip
// R18 - Fixed mode uses serial clock sample
// R19 - Aligned mode reads through FIFO
// R20 - Soft recovery forwards divided clock
// R21 - No aligner reset after soft training
// R22 - Lock flag invalid in soft recovery
// R23 - Rollover returns count to zero
// R24 - Resets touch only this channel
`timescale 1ns/10ps
`default_nettype none
module serial_rx_phase_align_deserializer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Line samples, one per clock phase
    input wire logic [7:0] phase_samples,
    // Parallel side
    output logic [9:0] par_data,
    output logic par_valid,
    output logic par_clk,
    output logic rollover_pulse,
    output logic lock_flag
);

    // First transition in the phase samples: {found, index}
    function automatic logic [3:0] find_edge(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 1; i < 8; i++) begin
            if (!r[3] && (v[i] != v[i - 1])) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Modulo-six pointer step
    function automatic logic [2:0] inc6(input logic [2:0] p);
        return (p == serial_rx_pkg::FIFO_LAST) ? 3'h0 : 3'(p + 3'h1);
    endfunction

    // Bits per parallel word
    function automatic logic [3:0] eff_factor(
        input serial_rx_pkg::ctrl_s c);
        logic [3:0] f;
        f = c.factor;
        if (c.bypass) begin
            f = c.ddr ? serial_rx_pkg::FACT_DDR : serial_rx_pkg::FACT_SDR;
        end else if (f < serial_rx_pkg::FACT_MIN) begin
            f = serial_rx_pkg::FACT_MIN;
        end else if (f > serial_rx_pkg::FACT_MAX) begin
            f = serial_rx_pkg::FACT_MAX;
        end
        return f;
    endfunction

    // Rollover point clamped into range
    function automatic logic [3:0] eff_roll(input logic [3:0] r);
        logic [3:0] v;
        v = r;
        if (v < serial_rx_pkg::ROLL_MIN) begin
            v = serial_rx_pkg::ROLL_MIN;
        end else if (v > serial_rx_pkg::ROLL_MAX) begin
            v = serial_rx_pkg::ROLL_MAX;
        end
        return v;
    endfunction

    // Mask of the low f bits of a word
    function automatic logic [9:0] word_mask(input logic [3:0] f);
        logic [9:0] m;
        m = 10'h000;
        for (int i = 0; i < 10; i++) begin
            m[i] = (i < int'(f));
        end
        return m;
    endfunction

    serial_rx_pkg::state_s s;
    serial_rx_pkg::state_s n;
    logic aligner_on;
    logic [3:0] edge_info;
    logic first_lock;
    logic fifo_clr;
    logic sel_bit;
    logic ser_bit;
    logic slipped;
    logic [3:0] fct;
    logic [3:0] roll;
    logic strobe;
    logic slip_edge;
    logic apb_setup;
    logic apb_commit;
    logic [9:0] shift_in;

    always_comb begin
        n = s;
        fct = eff_factor(s.ctrl);
        roll = eff_roll(s.ctrl.roll);
        // Three-stage pin synchroniser, change taken when 2nd and 3rd agree
        n.sync[0] = phase_samples;
        n.sync[1] = s.sync[0];
        n.sync[2] = s.sync[1];
        for (int i = 0; i < 8; i++) begin
            if (s.sync[1][i] == s.sync[2][i]) begin
                n.filt[i] = s.sync[2][i];
            end
        end

        // Phase aligner
        aligner_on = (s.ctrl.mode != serial_rx_pkg::MODE_FIXED)
            && !s.ctrl.bypass; // R9 R17
        edge_info = find_edge(s.filt); // R4
        first_lock = 1'b0;
        if (s.ctrl.aligner_rst) begin
            n.ast = serial_rx_pkg::ST_TRAIN; // R6 R24
            n.phase = 3'h0;
            n.lock = 1'b0;
        end else if (aligner_on && edge_info[3]
            && !s.ctrl.phase_select_hold) begin // R3
            // Sample opposite the data edge, at most 1/8 UI off
            n.phase = 3'(edge_info[2:0] + serial_rx_pkg::PH_CENTER); // R1 R2
            if (s.ast == serial_rx_pkg::ST_TRAIN) begin
                n.ast = serial_rx_pkg::ST_TRACK;
                n.lock = 1'b1; // R5
                first_lock = 1'b1;
            end
        end
        case (s.ast)
            serial_rx_pkg::ST_TRAIN: n.lock_out = 1'b0;
            serial_rx_pkg::ST_TRACK: n.lock_out = n.lock;
            default: n.ast = serial_rx_pkg::ST_TRAIN;
        endcase
        if (s.ctrl.mode == serial_rx_pkg::MODE_SOFT_CDR) begin
            n.lock_out = 1'b0; // R22
        end
        sel_bit = s.filt[s.phase];

        // APB decode
        apb_setup = psel && penable && !s.pready;
        apb_commit = psel && penable && s.pready;
        fifo_clr = first_lock; // R8
        if (apb_commit && pwrite && (paddr == serial_rx_pkg::ADDR_CMD)) begin
            fifo_clr = fifo_clr
                || pwdata[serial_rx_pkg::CMD_FIFO_RST_BIT]; // R8 R24
        end

        // Phase FIFO, fixed read lag of three entries
        if (fifo_clr) begin
            n.fifo = 6'h00;
            n.wr = serial_rx_pkg::FIFO_PREFILL;
            n.rd = 3'h0;
        end else begin
            n.fifo[s.wr] = sel_bit; // R7
            n.wr = inc6(s.wr);
            n.rd = inc6(s.rd);
        end

        // Serial bit source per mode
        if (s.ctrl.bypass) begin
            ser_bit = s.filt[0]; // R16
        end else begin
            case (s.ctrl.mode)
                serial_rx_pkg::MODE_ALIGNED: ser_bit = s.fifo[s.rd]; // R19
                serial_rx_pkg::MODE_SOFT_CDR: ser_bit = sel_bit; // R20 R9
                default: ser_bit = s.filt[0]; // R18 R9
            endcase
        end

        // Bit slip: tap the history at the inserted latency
        n.hist = {s.hist[10:0], ser_bit};
        slipped = s.ctrl.bypass ? ser_bit : n.hist[s.slip_cnt]; // R10 R17

        // Deserializer
        // Counter past a shrunk factor strobes at once
        strobe = (s.bitcnt >= 4'(fct - 4'h1));
        shift_in = {s.shift[8:0], slipped};
        n.shift = shift_in;
        n.word_valid = strobe; // R15
        n.bitcnt = strobe ? 4'h0 : 4'(s.bitcnt + 4'h1);
        if (strobe) begin
            n.word = shift_in & word_mask(fct); // R15 R16 R12
        end
        n.par_clk = (n.bitcnt < 4'((fct + 4'h1) >> 1)); // R20 R22

        // Slip request sampled at each parallel clock edge
        slip_edge = strobe && s.ctrl.slip_req && !s.slip_prev
            && !s.ctrl.bypass; // R10 R17
        if (strobe) begin
            n.slip_prev = s.ctrl.slip_req;
            n.roll_out = s.roll_pend; // R14
            n.roll_pend = 1'b0;
        end
        if (slip_edge) begin
            if (s.slip_cnt >= 4'(roll - 4'h1)) begin
                n.slip_cnt = 4'h0; // R13 R23
                n.roll_pend = 1'b1;
            end else begin
                n.slip_cnt = 4'(s.slip_cnt + 4'h1); // R10
            end
        end

        // APB slave, one wait state
        n.pready = apb_setup;
        n.pslverr = 1'b0;
        if (apb_setup) begin
            n.prdata = 32'h0000_0000;
            case (paddr)
                serial_rx_pkg::ADDR_CTRL:
                    n.prdata = {17'h00000, s.ctrl};
                serial_rx_pkg::ADDR_CMD:
                    n.prdata = 32'h0000_0000;
                serial_rx_pkg::ADDR_STATUS:
                    n.prdata = {24'h000000, s.slip_cnt, s.phase, s.lock_out};
                serial_rx_pkg::ADDR_DATA:
                    n.prdata = {22'h000000, s.word};
                default:
                    n.pslverr = 1'b1;
            endcase
        end
        if (apb_commit && pwrite && (paddr == serial_rx_pkg::ADDR_CTRL)) begin
            n.ctrl = serial_rx_pkg::ctrl_s'(
                pwdata[serial_rx_pkg::CTRL_W-1:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= serial_rx_pkg::STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign par_data = s.word;
    assign par_valid = s.word_valid;
    assign par_clk = s.par_clk;
    assign rollover_pulse = s.roll_out;
    assign lock_flag = s.lock_out;

    // Checks
    logic [3:0] fifo_gap;
    assign fifo_gap = (s.wr >= s.rd) ? 4'(s.wr - s.rd)
        : 4'(s.wr + 4'h6 - s.rd);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_hold_phase;
        s.ctrl.phase_select_hold && !s.ctrl.aligner_rst |=> $stable(s.phase);
    endproperty
    a_hold_phase: assert property (p_hold_phase) // R3
        else $error("phase moved while held");

    property p_lock_sticky;
        s.lock && !s.ctrl.aligner_rst |=> s.lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) // R5
        else $error("lock dropped without reset");

    property p_aligner_reset;
        s.ctrl.aligner_rst |=> !s.lock && (s.ast == serial_rx_pkg::ST_TRAIN)
            ##1 !lock_flag;
    endproperty
    a_aligner_reset: assert property (p_aligner_reset) // R6
        else $error("aligner reset did not retrain");

    property p_fifo_gap;
        fifo_gap == 4'h3;
    endproperty
    a_fifo_gap: assert property (p_fifo_gap) // R7
        else $error("phase FIFO lag is not three");

    property p_fifo_first_lock;
        !s.lock && n.lock |=> (s.wr == serial_rx_pkg::FIFO_PREFILL)
            && (s.rd == 3'h0) && (s.fifo == 6'h00);
    endproperty
    a_fifo_first_lock: assert property (p_fifo_first_lock) // R8
        else $error("FIFO not cleared on first lock");

    property p_fixed_path;
        (s.ctrl.mode == serial_rx_pkg::MODE_FIXED) && !s.ctrl.aligner_rst
            |=> $stable(s.phase);
    endproperty
    a_fixed_path: assert property (p_fixed_path) // R9
        else $error("aligner active in fixed mode");

    property p_slip_step;
        slip_edge && (s.slip_cnt < 4'(roll - 4'h1))
            |=> s.slip_cnt == $past(s.slip_cnt) + 4'h1;
    endproperty
    a_slip_step: assert property (p_slip_step) // R10
        else $error("slip did not add one bit");

    property p_rollover;
        slip_edge && (s.slip_cnt >= 4'(roll - 4'h1))
            |=> (s.slip_cnt == 4'h0) && s.roll_pend;
    endproperty
    a_rollover: assert property (p_rollover) // R13 R23
        else $error("rollover did not wrap");

    property p_roll_one_word;
        s.roll_out && !strobe |=> s.roll_out;
    endproperty
    a_roll_one_word: assert property (p_roll_one_word) // R14
        else $error("rollover pulse shorter than a word");

    property p_roll_ends;
        s.roll_out && strobe && !s.roll_pend |=> !s.roll_out;
    endproperty
    a_roll_ends: assert property (p_roll_ends) // R14
        else $error("rollover pulse longer than a word");

    property p_bypass_no_slip;
        s.ctrl.bypass && !s.ctrl.aligner_rst
            |=> $stable(s.slip_cnt) && $stable(s.phase);
    endproperty
    a_bypass_no_slip: assert property (p_bypass_no_slip) // R17
        else $error("slip or aligner used in bypass");

    property p_soft_lock;
        s.ctrl.mode == serial_rx_pkg::MODE_SOFT_CDR |=> !lock_flag;
    endproperty
    a_soft_lock: assert property (p_soft_lock) // R22
        else $error("lock flag shown in soft recovery");

    property p_word_spacing;
        par_valid && (fct > 4'h1) && $stable(s.ctrl) |=> !par_valid;
    endproperty
    a_word_spacing: assert property (p_word_spacing) // R15
        else $error("words closer than the factor");

    property p_apb_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("APB answer late");

    c_first_lock: cover property (!s.lock ##1 s.lock);
    c_rollover: cover property (rollover_pulse);
    c_phase_move: cover property (s.lock && !$stable(s.phase));
    c_slip: cover property (slip_edge);

endmodule // serial_rx_phase_align_deserializer
`default_nettype wire

// ===== design/serial_rx_pkg.sv
// Purpose: Shared constants and types for the serial receive channel
// Assumes: One channel, APB register access, pclk domain only
// Notes: Widths and depths are fixed
`default_nettype none
package serial_rx_pkg;
    // Phase aligner
    localparam int unsigned NUM_PHASES = 8;
    localparam logic [2:0] PH_CENTER = 3'h4;
    // Phase FIFO, six entries of one bit
    localparam int unsigned FIFO_DEPTH = 6;
    localparam logic [2:0] FIFO_LAST = 3'h5;
    localparam logic [2:0] FIFO_PREFILL = 3'h3;
    // Realignment and deserializer
    localparam int unsigned HIST_W = 12;
    localparam int unsigned WORD_W = 10;
    localparam logic [3:0] FACT_MIN = 4'h3;
    localparam logic [3:0] FACT_MAX = 4'hA;
    localparam logic [3:0] FACT_SDR = 4'h1;
    localparam logic [3:0] FACT_DDR = 4'h2;
    localparam logic [3:0] ROLL_MIN = 4'h1;
    localparam logic [3:0] ROLL_MAX = 4'hB;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam int unsigned CTRL_W = 15;
    localparam int unsigned CMD_FIFO_RST_BIT = 0;

    typedef enum logic [1:0] {
        MODE_FIXED = 2'h0,
        MODE_ALIGNED = 2'h1,
        MODE_SOFT_CDR = 2'h2
    } mode_e;

    typedef enum logic [1:0] {
        ST_TRAIN = 2'b01,
        ST_TRACK = 2'b10
    } align_state_e;

    // CTRL layout, bit 0 upward: mode, bypass, ddr, factor, roll,
    // hold, aligner reset, slip request
    typedef struct packed {
        logic slip_req;
        logic aligner_rst;
        logic phase_select_hold;
        logic [3:0] roll;
        logic [3:0] factor;
        logic ddr;
        logic bypass;
        mode_e mode;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '{
        slip_req: 1'b0, aligner_rst: 1'b0, phase_select_hold: 1'b0,
        roll: 4'hA, factor: 4'hA, ddr: 1'b0, bypass: 1'b0,
        mode: MODE_ALIGNED};

    typedef struct packed {
        logic [2:0][7:0] sync;
        logic [7:0] filt;
        align_state_e ast;
        logic [2:0] phase;
        logic lock;
        logic lock_out;
        logic [5:0] fifo;
        logic [2:0] wr;
        logic [2:0] rd;
        logic [11:0] hist;
        logic [3:0] slip_cnt;
        logic slip_prev;
        logic roll_pend;
        logic roll_out;
        logic [3:0] bitcnt;
        logic [9:0] shift;
        logic [9:0] word;
        logic word_valid;
        logic par_clk;
        ctrl_s ctrl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;

    localparam state_s STATE_RST = '{
        ctrl: CTRL_RST, ast: ST_TRAIN, wr: FIFO_PREFILL, default: '0};
endpackage
`default_nettype wire

// ===== verification/line_source.sv
// Purpose: Upstream serial source seen as eight phase samples
// Assumes: One bit time per pclk cycle
// Notes: Word sent from bit factor-1 down, repeating; runs shorter
//        than two bits are lost in the receiver's pin filter
`timescale 1ns/10ps
`default_nettype none
module line_source (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pattern control
    input wire logic [9:0] word,
    input wire logic [3:0] factor,
    input wire logic [2:0] edge_pos,
    // Line samples
    output logic [7:0] phase_samples
);
    logic [3:0] idx;
    logic prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx <= 4'h0;
            prev <= 1'b0;
            phase_samples <= 8'h00;
        end else begin
            // Phases before the edge still see the old bit
            for (int k = 0; k < 8; k++) begin
                phase_samples[k] <= (k < edge_pos) ? prev : word[idx];
            end
            prev <= word[idx];
            idx <= (idx == 4'h0) ? factor - 4'h1 : idx - 4'h1;
        end
    end
endmodule // line_source
`default_nettype wire

// ===== verification/serial_rx_phase_align_deserializer_bench.sv
// Purpose: Self-checking bench for the serial receive channel
// Assumes: APB answer within 20 cycles
// Notes: Source repeats an 8-bit pattern
`timescale 1ns/10ps
`default_nettype none
module serial_rx_phase_align_deserializer_bench;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [7:0] paddr, d0;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, par_valid, par_clk, rollover_pulse, lock_flag;
    logic [7:0] phase_samples;
    logic [9:0] par_data, src_word;
    logic [2:0] src_edge, p0;
    logic [3:0] c0;
    serial_rx_pkg::ctrl_s cfg;
    int n_fail, compares, n;
    // Runs of two bits or more pass the pin filter
    localparam logic [7:0] PAT = 8'hE0;
    serial_rx_phase_align_deserializer DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_samples(phase_samples),
        .par_data(par_data), .par_valid(par_valid), .par_clk(par_clk),
        .rollover_pulse(rollover_pulse), .lock_flag(lock_flag));
    line_source src (.pclk(pclk), .presetn(presetn), .word(src_word),
        .factor(4'h8), .edge_pos(src_edge), .phase_samples(phase_samples));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic results;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return par_valid;
            1: return par_clk;
            2: return lock_flag;
            default: return rollover_pulse;
        endcase
    endfunction
    task automatic waitfor(input int s, input logic v);
        for (int i = 0; i < 300; i++) begin
            @(negedge pclk);
            if (sig(s) === v) return;
        end
        chk(sig(s), v);
        results();
    endtask
    task automatic count_hi(input int s, output int k);
        k = 0;
        repeat (16) begin
            if (sig(s) === 1'b1) k++;
            @(negedge pclk);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk(pready, 1'b1);
            results();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic setc;
        apb(1'b1, serial_rx_pkg::ADDR_CTRL, {17'h0, cfg}, rd);
        repeat (4) @(posedge pclk);
    endtask
    task automatic status;
        apb(1'b0, serial_rx_pkg::ADDR_STATUS, 32'h0, rd);
    endtask
    task automatic poll_phase;
        for (int i = 0; i < 30; i++) begin
            status();
            if (rd[3:1] !== p0) return;
        end
    endtask
    task automatic check_word;
        logic [15:0] dd;
        logic hit;
        dd = {2{PAT}};
        hit = 1'b0;
        // Let FIFO clears and phase moves flush the shifter
        repeat (16) @(negedge pclk);
        waitfor(0, 1'b1);
        for (int k = 0; k < 8; k++) begin
            if (par_data[7:0] === dd[k +: 8]) hit = 1'b1;
        end
        chk({par_data[9:8], hit}, 3'h1);
    endtask
    task automatic t_regs;
        apb(1'b0, serial_rx_pkg::ADDR_CTRL, 32'h0, rd);
        chk(rd, {17'h0, serial_rx_pkg::CTRL_RST});
        apb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, serial_rx_pkg::ADDR_CMD, 32'h0, rd);
        chk(rd, 32'h0);
        chk(lock_flag, 1'b0);
        $display("regs done");
    endtask
    task automatic t_lock;
        cfg.factor = 4'h8;
        setc();
        src_word <= {2'h0, PAT};
        waitfor(2, 1'b1);
        count_hi(0, n);
        chk(n, 2);
        check_word();
        apb(1'b1, serial_rx_pkg::ADDR_CMD, 32'h1, rd);
        repeat (10) @(posedge pclk);
        check_word();
        $display("lock done");
    endtask
    task automatic t_track;
        status();
        p0 = rd[3:1];
        src_edge <= 3'h5;
        poll_phase();
        chk(3'(rd[3:1] - p0), 3'h3);
        chk(lock_flag, 1'b1);
        cfg.phase_select_hold = 1'b1;
        setc();
        p0 = rd[3:1];
        status();
        p0 = rd[3:1];
        src_edge <= 3'h1;
        repeat (30) @(posedge pclk);
        status();
        chk(rd[3:1], p0);
        cfg.phase_select_hold = 1'b0;
        setc();
        poll_phase();
        chk(3'(rd[3:1] - p0), 3'h4);
        $display("track done");
    endtask
    task automatic t_slip;
        cfg.roll = 4'h2;
        setc();
        waitfor(0, 1'b1);
        d0 = par_data[7:0];
        cfg.slip_req = 1'b1;
        setc();
        repeat (20) @(posedge pclk);
        cfg.slip_req = 1'b0;
        setc();
        repeat (20) @(posedge pclk);
        waitfor(0, 1'b1);
        chk(par_data[7:0], {d0[0], d0[7:1]});
        status();
        chk(rd[7:4], 4'h1);
        cfg.slip_req = 1'b1;
        setc();
        waitfor(3, 1'b1);
        count_hi(3, n);
        chk(n, 8);
        cfg.slip_req = 1'b0;
        setc();
        status();
        chk(rd[7:4], 4'h0);
        $display("slip done");
    endtask
    task automatic t_areset;
        cfg.aligner_rst = 1'b1;
        setc();
        status();
        chk({lock_flag, rd[3:1]}, 4'h0);
        cfg.aligner_rst = 1'b0;
        setc();
        waitfor(2, 1'b1);
        check_word();
        $display("aligner reset done");
    endtask
    task automatic t_modes;
        cfg.mode = serial_rx_pkg::MODE_SOFT_CDR;
        setc();
        chk(lock_flag, 1'b0);
        count_hi(1, n);
        chk(n, 8);
        cfg.mode = serial_rx_pkg::MODE_FIXED;
        setc();
        repeat (40) @(posedge pclk);
        check_word();
        $display("modes done");
    endtask
    task automatic t_bypass;
        status();
        c0 = rd[7:4];
        cfg.bypass = 1'b1;
        setc();
        count_hi(0, n);
        chk(n, 16);
        cfg.ddr = 1'b1;
        setc();
        count_hi(0, n);
        chk(n, 8);
        cfg.slip_req = 1'b1;
        setc();
        repeat (20) @(posedge pclk);
        cfg.slip_req = 1'b0;
        setc();
        status();
        chk(rd[7:4], c0);
        $display("bypass done");
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_word = 10'h000;
        src_edge = 3'h2;
        n_fail = 0;
        compares = 0;
        cfg = serial_rx_pkg::CTRL_RST;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_lock();
        t_track();
        t_slip();
        t_areset();
        t_modes();
        t_bypass();
        results();
    end
endmodule // serial_rx_phase_align_deserializer_bench
`default_nettype wire
